// ==== core/pmc_pkg.sv ====
// Shared constants and types for the phasor measurement configuration block
package pmc_pkg;

	// Clock and timing
	localparam int CLK_HZ  = 200_000_000;
	localparam int TOL_US  = 10;
	localparam int TOL_CYC = TOL_US * (CLK_HZ / 1_000_000);
	localparam int NPORT   = 3;
	localparam int SAMPLE_CYC = 50_000;

	// Angles in hundredths of a degree
	localparam logic signed [16:0] ANG_MAX  = 17'sh04650;
	localparam logic signed [16:0] ANG_MIN  = -17'sh0464F;
	localparam logic signed [16:0] ANG_TURN = 17'sh08CA0;

	// Register byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_UID   = 8'h04;
	localparam logic [7:0] A_VOFF  = 8'h08;
	localparam logic [7:0] A_IOFF  = 8'h0C;
	localparam logic [7:0] A_TRIG  = 8'h10;
	localparam logic [7:0] A_STAT  = 8'h14;
	localparam logic [7:0] A_SEC   = 8'h18;
	localparam logic [7:0] A_PORT0 = 8'h20;

	// Control register fields
	localparam int B_EN   = 0;
	localparam int B_TCB  = 1;
	localparam int B_VSET = 2;
	localparam int B_ISET = 4;
	localparam int B_NANA = 6;
	localparam int B_NDSW = 9;
	localparam int B_RATE = 12;

	// Trigger register fields
	localparam int B_TREA = 0;
	localparam int B_MASK = 4;

	// Port register fields
	localparam int P_STREAM = 0;
	localparam int P_BAUD   = 1;
	localparam int P_STOP2  = 4;
	localparam int P_RTS    = 5;
	localparam int P_DBITS  = 8;
	localparam int P_PARITY = 12;

	// Reset values and limits
	localparam logic [3:0]  RST_RATE  = 4'hA;
	localparam logic [15:0] RST_UID   = 16'h0001;
	localparam logic [15:0] UID_MAX   = 16'hFFFE;
	localparam logic [2:0]  RST_BAUD  = 3'h4;
	localparam logic [2:0]  BAUD_MAX  = 3'h6;
	localparam logic [2:0]  ANA_MAX   = 3'h4;
	localparam logic [3:0]  RST_TREA  = 4'hF;
	localparam logic [3:0]  RST_MASK  = 4'hF;
	localparam logic [3:0]  DATA_BITS = 4'h8;
	localparam logic [3:0]  N_SLOTS   = 4'hA;
	localparam logic [3:0]  SLOT_I1   = 4'h5;

	typedef enum logic [1:0] {SET_POS, SET_ALL, SET_NONE} pmc_set_t;
	typedef enum logic [1:0] {CMD_TEXT, CMD_FILE, CMD_METER} pmc_cmd_t;
	typedef enum logic {TCB_IGNORE, TCB_C37} pmc_tcb_t;

	typedef struct packed {
		logic       stream;
		logic [2:0] baud;
		logic       stop2;
		logic       rts;
	} pmc_port_t;

endpackage

// ==== core/pmc_angle_if.sv ====
// Angle correction request and result between sequencer and corrector
`timescale 1ns/1ps
interface pmc_angle_if;
	logic               valid;
	logic signed [15:0] angle;
	logic signed [15:0] offset;
	logic               out_valid;
	logic signed [15:0] out_angle;

	modport src (output valid, angle, offset, input out_valid, out_angle);
	modport cor (input valid, angle, offset, output out_valid, out_angle);
endinterface

// ==== core/pmc_angle_corr.sv ====
// Adds an angle offset to a measured angle and wraps the sum
`timescale 1ns/1ps
module pmc_angle_corr (
	// Clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_srst,
	// Angle request and result
	pmc_angle_if.cor   ang
);

	typedef struct packed {
		logic               v;
		logic signed [15:0] a;
	} pmc_corr_t;

	pmc_corr_t          q;
	pmc_corr_t          d;
	logic signed [16:0] sum;

	always_comb
	begin
		d = q;
		sum = 17'(ang.angle) + 17'(ang.offset);
		// [RULE_24] wrap into range
		if (sum > pmc_pkg::ANG_MAX)
			sum = sum - pmc_pkg::ANG_TURN;
		else if (sum <= -pmc_pkg::ANG_MAX)
			sum = sum + pmc_pkg::ANG_TURN;
		d.v = ang.valid;
		// [RULE_05] offset added to angle
		if (ang.valid)
			d.a = sum[15:0];
		if (i_srst)
			d = '0;
	end

	always_ff @(posedge i_clk)
	begin
		q <= d;
	end

	assign ang.out_valid = q.v;
	assign ang.out_angle = q.a;

endmodule

// ==== core/pmc_phasor_cfg.sv ====
// Phasor measurement settings, time base, sampling and packet sequencing
//
// Summary of operation
// [RULE_01] Time source flag rises only when the time reference is accurate enough.
// [RULE_02] Phasor sampling continues while the time source flag is low.
// [RULE_03] Meter command is refused while the time source flag is low.
// [RULE_04] Four voltages and four currents sampled on fixed base, time stamped.
// [RULE_05] Signed voltage and current angle offsets added to measured angles.
// [RULE_06] Angle offsets accepted from -179.99 to 180 degrees, reset to zero.
// [RULE_07] Enable off stops collection and hides all other phasor settings.
// [RULE_08] Message rate limited to 1, 2, 5 or 10 per second, default 10.
// [RULE_09] Unit identifier accepted from 1 to 65534, default 1.
// [RULE_10] Voltage set is positive-sequence, all or none; default positive-sequence.
// [RULE_11] Current set is positive-sequence, all or none; default none.
// [RULE_12] Analog value count accepted from 0 to 4, default 0.
// [RULE_13] Digital word count is 0 or 1 for one 16-bit word, default 0.
// [RULE_14] Four trigger reason bits; trigger defaults to OR of all four.
// [RULE_15] Time control bits ignored or interpreted per mode, default ignore.
// [RULE_16] Current angle offset hidden while current set is none.
// [RULE_17] Streaming port framing fixed at 8 data bits, no parity.
// [RULE_18] Streaming protocol cannot be chosen on serial port 1.
// [RULE_19] Port speed one of seven rates, default 9600, one or two stops.
// [RULE_20] Optional hardware request/clear-to-send handshake, off by default.
// [RULE_21] Streaming port with enable off answers no commands at all.
// [RULE_22] Streaming port refuses commands; only other source restores its protocol.
// [RULE_23] Selected voltage phasors go before selected current phasors in packets.
// [RULE_24] Corrected angle wraps into the range above -180 up to 180.
`timescale 1ns/1ps
module pmc_phasor_cfg #(
	parameter int         NPORT      = pmc_pkg::NPORT,
	parameter int         SEC_CYC    = pmc_pkg::CLK_HZ,
	parameter int         SAMPLE_CYC = pmc_pkg::SAMPLE_CYC,
	parameter logic [3:0] QUAL_MAX   = 4'h5,
	parameter int         PW         = $clog2(NPORT + 1)
) (
	// Clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_srst,
	// Register port
	input  wire logic [7:0]                   i_addr,
	input  wire logic [31:0]                  i_wdata,
	input  wire logic                         i_wr,
	input  wire logic                         i_rd,
	input  wire logic [PW-1:0]                i_cfg_src,
	output logic      [31:0]                  o_rdata,
	// Time reference pins
	input  wire logic                         i_irig_pps,
	input  wire logic [3:0]                   i_irig_qual,
	output logic                              o_time_source_ok,
	// Sampling
	output logic                              o_sample_strobe,
	output logic      [31:0]                  o_sample_sec,
	output logic      [31:0]                  o_sample_frac,
	// Packet sequencing
	input  wire logic signed [15:0]           i_meas_angle,
	output logic      [3:0]                   o_slot_id,
	output logic                              o_msg_start,
	output logic                              o_slot_valid,
	output logic      [3:0]                   o_slot_tag,
	output logic signed [15:0]                o_slot_angle,
	output logic      [2:0]                   o_pkt_analogs,
	output logic                              o_pkt_digital,
	// Triggers
	input  wire logic [3:0]                   i_trig_src,
	output logic      [3:0]                   o_trigger_reason_bits,
	output logic                              o_phasor_trigger,
	// Commands
	input  wire logic                         i_cmd_valid,
	input  wire logic [PW-1:0]                i_cmd_port,
	input  wire pmc_pkg::pmc_cmd_t            i_cmd_kind,
	output logic                              o_cmd_accept,
	output logic                              o_cmd_reject,
	// Serial port settings
	output logic      [NPORT-1:0]             o_port_stream,
	output logic      [NPORT-1:0]             o_port_silent,
	output logic      [NPORT-1:0][2:0]        o_port_baud,
	output logic      [NPORT-1:0]             o_port_stop2,
	output logic      [NPORT-1:0]             o_port_rtscts
);

	localparam logic [31:0] SEC_LO    = 32'(SEC_CYC - pmc_pkg::TOL_CYC);
	localparam logic [31:0] SEC_HI    = 32'(SEC_CYC + pmc_pkg::TOL_CYC);
	localparam logic [31:0] SAMP_LAST = 32'(SAMPLE_CYC - 1);

	typedef enum logic {WK_IDLE, WK_RUN} pmc_walk_t;

	typedef struct packed {
		logic                             en;
		pmc_pkg::pmc_tcb_t                tcb;
		pmc_pkg::pmc_set_t                vset;
		pmc_pkg::pmc_set_t                iset;
		logic [2:0]                       nana;
		logic                             ndsw;
		logic [3:0]                       rate;
		logic [15:0]                      uid;
		logic signed [15:0]               voff;
		logic signed [15:0]               ioff;
		logic [3:0]                       trea_en;
		logic [3:0]                       mask;
		pmc_pkg::pmc_port_t [NPORT-1:0]   port;
		logic                             pps_s1;
		logic                             pps_s2;
		logic                             pps_d;
		logic [3:0]                       qual_s1;
		logic [3:0]                       qual_s2;
		logic                             locked;
		logic                             time_source_ok;
		logic [31:0]                      ivl;
		logic [31:0]                      sec;
		logic [31:0]                      frac;
		logic [31:0]                      scnt;
		logic [31:0]                      mcnt;
		logic                             samp;
		logic [31:0]                      st_sec;
		logic [31:0]                      st_frac;
		pmc_walk_t                        walk;
		logic [3:0]                       slot;
		logic [3:0]                       tag;
		logic                             msg;
		logic [3:0]                       trea;
		logic                             ptrig;
		logic                             acc;
		logic                             rej;
		logic [31:0]                      rdata;
	} pmc_state_t;

	pmc_state_t  q;
	pmc_state_t  d;
	pmc_angle_if ang ();

	// Cycles between message starts for a rate code
	function automatic logic [31:0] msg_period(input logic [3:0] r);
		case (r)
			4'h1:    msg_period = 32'(SEC_CYC);
			4'h2:    msg_period = 32'(SEC_CYC / 2);
			4'h5:    msg_period = 32'(SEC_CYC / 5);
			default: msg_period = 32'(SEC_CYC / 10);
		endcase
	endfunction

	function automatic logic off_ok(input logic [15:0] v);
		off_ok = ($signed({v[15], v}) >= pmc_pkg::ANG_MIN) &&
			($signed({v[15], v}) <= pmc_pkg::ANG_MAX);
	endfunction

	function automatic logic [7:0] port_addr(input int k);
		port_addr = 8'(int'(pmc_pkg::A_PORT0) + 4 * k);
	endfunction

	// Slot order: V1, VA, VB, VC, VS, I1, IA, IB, IC, IN
	function automatic logic slot_on(input logic [3:0] s, input pmc_pkg::pmc_set_t vs,
		input pmc_pkg::pmc_set_t is);
		if (s == 4'h0)
			slot_on = (vs != pmc_pkg::SET_NONE);
		else if (s < pmc_pkg::SLOT_I1)
			slot_on = (vs == pmc_pkg::SET_ALL);
		else if (s == pmc_pkg::SLOT_I1)
			slot_on = (is != pmc_pkg::SET_NONE);
		else
			slot_on = (is == pmc_pkg::SET_ALL);
	endfunction

	logic        pps_edge;
	logic        port_ok;
	logic        blocked;
	logic [31:0] r;

	always_comb
	begin
		d = q;
		r = '0;
		port_ok = 1'b0;
		blocked = 1'b0;

		d.pps_s1 = i_irig_pps;
		d.pps_s2 = q.pps_s1;
		d.pps_d = q.pps_s2;
		d.qual_s1 = i_irig_qual;
		d.qual_s2 = q.qual_s1;
		pps_edge = q.pps_s2 && !q.pps_d;

		// Second marks one second apart within tolerance keep the lock
		if (q.ivl <= SEC_HI)
			d.ivl = q.ivl + 32'h1;
		else
			d.locked = 1'b0;
		d.frac = q.frac + 32'h1;
		if (pps_edge)
		begin
			d.locked = (q.ivl >= SEC_LO) && (q.ivl <= SEC_HI);
			d.ivl = '0;
			d.frac = '0;
			d.sec = q.sec + 32'h1;
		end
		// [RULE_01] accuracy qualifies flag
		// [RULE_15] quality used only in extension mode
		d.time_source_ok = q.locked && (q.tcb == pmc_pkg::TCB_IGNORE || q.qual_s2 <= QUAL_MAX);

		// [RULE_04] fixed sample base
		d.samp = 1'b0;
		d.scnt = (pps_edge || q.scnt >= SAMP_LAST) ? '0 : q.scnt + 32'h1;
		// [RULE_02] sampling ignores flag
		// [RULE_07] no collection when disabled
		if (q.en && q.scnt >= SAMP_LAST)
		begin
			d.samp = 1'b1;
			d.st_sec = q.sec;
			d.st_frac = q.frac;
		end

		// [RULE_08] message pacing
		d.msg = 1'b0;
		d.mcnt = (pps_edge || q.mcnt >= msg_period(q.rate) - 32'h1) ? '0 : q.mcnt + 32'h1;
		if (q.en && q.walk == WK_IDLE && q.mcnt >= msg_period(q.rate) - 32'h1)
		begin
			d.msg = 1'b1;
			d.walk = WK_RUN;
			d.slot = '0;
		end

		// [RULE_23] voltages walk first
		case (q.walk)
			WK_IDLE:
				d.tag = q.tag;
			WK_RUN:
			begin
				d.tag = q.slot;
				d.slot = q.slot + 4'h1;
				if (q.slot == pmc_pkg::N_SLOTS - 4'h1)
					d.walk = WK_IDLE;
			end
			default:
				d.walk = WK_IDLE;
		endcase

		// [RULE_14] reasons and trigger
		d.trea = i_trig_src & q.trea_en;
		d.ptrig = |(i_trig_src & q.trea_en & q.mask);

		// [RULE_03] meter needs good time
		// [RULE_21] silent streaming port
		// [RULE_22] streaming port refuses commands
		d.acc = 1'b0;
		d.rej = 1'b0;
		for (int k = 0; k < NPORT; k++)
		begin
			if (i_cmd_port == PW'(k + 1))
			begin
				port_ok = 1'b1;
				blocked = q.port[k].stream;
			end
		end
		if (i_cmd_valid)
		begin
			if (!port_ok || blocked ||
				(i_cmd_kind == pmc_pkg::CMD_METER && (!q.en || !q.time_source_ok)))
				d.rej = 1'b1;
			else
				d.acc = 1'b1;
		end

		// Register writes; phasor settings other than enable are hidden while disabled, port settings are not
		if (i_wr)
		begin
			case (i_addr)
				pmc_pkg::A_CTRL:
				begin
					d.en = i_wdata[pmc_pkg::B_EN];
					// [RULE_07] fields need enable
					if (i_wdata[pmc_pkg::B_EN])
					begin
						d.tcb = pmc_pkg::pmc_tcb_t'(i_wdata[pmc_pkg::B_TCB]);
						// [RULE_10] voltage set choices
						if (i_wdata[pmc_pkg::B_VSET +: 2] != 2'h3)
							d.vset = pmc_pkg::pmc_set_t'(i_wdata[pmc_pkg::B_VSET +: 2]);
						// [RULE_11] current set choices
						if (i_wdata[pmc_pkg::B_ISET +: 2] != 2'h3)
							d.iset = pmc_pkg::pmc_set_t'(i_wdata[pmc_pkg::B_ISET +: 2]);
						// [RULE_12] analog count limit
						if (i_wdata[pmc_pkg::B_NANA +: 3] <= pmc_pkg::ANA_MAX)
							d.nana = i_wdata[pmc_pkg::B_NANA +: 3];
						// [RULE_13] one digital word
						d.ndsw = i_wdata[pmc_pkg::B_NDSW];
						// [RULE_08] legal rates only
						if (i_wdata[pmc_pkg::B_RATE +: 4] inside {4'h1, 4'h2, 4'h5, 4'hA})
							d.rate = i_wdata[pmc_pkg::B_RATE +: 4];
					end
				end
				pmc_pkg::A_UID:
				begin
					// [RULE_09] identifier range
					if (q.en && i_wdata[15:0] != 16'h0000 && i_wdata[15:0] <= pmc_pkg::UID_MAX)
						d.uid = i_wdata[15:0];
				end
				pmc_pkg::A_VOFF:
				begin
					// [RULE_06] offset range check
					if (q.en && off_ok(i_wdata[15:0]))
						d.voff = i_wdata[15:0];
				end
				pmc_pkg::A_IOFF:
				begin
					// [RULE_16] hidden with no currents
					if (q.en && q.iset != pmc_pkg::SET_NONE && off_ok(i_wdata[15:0]))
						d.ioff = i_wdata[15:0];
				end
				pmc_pkg::A_TRIG:
				begin
					if (q.en)
					begin
						d.trea_en = i_wdata[pmc_pkg::B_TREA +: 4];
						d.mask = i_wdata[pmc_pkg::B_MASK +: 4];
					end
				end
				default:
				begin
					for (int k = 0; k < NPORT; k++)
					begin
						if (i_addr == port_addr(k))
						begin
							// [RULE_18] first port never streams
							// [RULE_22] restore from another source
							if (k != 0 && !(i_cfg_src == PW'(k + 1) && q.port[k].stream))
								d.port[k].stream = i_wdata[pmc_pkg::P_STREAM];
							// [RULE_19] speed and stop bits
							if (i_wdata[pmc_pkg::P_BAUD +: 3] <= pmc_pkg::BAUD_MAX)
								d.port[k].baud = i_wdata[pmc_pkg::P_BAUD +: 3];
							d.port[k].stop2 = i_wdata[pmc_pkg::P_STOP2];
							// [RULE_20] optional handshake
							d.port[k].rts = i_wdata[pmc_pkg::P_RTS];
						end
					end
				end
			endcase
		end

		// Register reads; data stands only in the following cycle
		if (i_rd)
		begin
			case (i_addr)
				pmc_pkg::A_CTRL:
				begin
					r[pmc_pkg::B_EN] = q.en;
					if (q.en)
					begin
						r[pmc_pkg::B_TCB] = q.tcb;
						r[pmc_pkg::B_VSET +: 2] = q.vset;
						r[pmc_pkg::B_ISET +: 2] = q.iset;
						r[pmc_pkg::B_NANA +: 3] = q.nana;
						r[pmc_pkg::B_NDSW] = q.ndsw;
						r[pmc_pkg::B_RATE +: 4] = q.rate;
					end
				end
				pmc_pkg::A_UID:
					r = q.en ? {16'h0000, q.uid} : '0;
				pmc_pkg::A_VOFF:
					r = q.en ? 32'(q.voff) : '0;
				pmc_pkg::A_IOFF:
					r = (q.en && q.iset != pmc_pkg::SET_NONE) ? 32'(q.ioff) : '0;
				pmc_pkg::A_TRIG:
					r = q.en ? {24'h000000, q.mask, q.trea_en} : '0;
				pmc_pkg::A_STAT:
					r = {24'h000000, 1'b0, q.ptrig, q.trea, q.locked, q.time_source_ok};
				pmc_pkg::A_SEC:
					r = q.sec;
				default:
				begin
					for (int k = 0; k < NPORT; k++)
					begin
						if (i_addr == port_addr(k))
						begin
							r[pmc_pkg::P_STREAM] = q.port[k].stream;
							r[pmc_pkg::P_BAUD +: 3] = q.port[k].baud;
							r[pmc_pkg::P_STOP2] = q.port[k].stop2;
							r[pmc_pkg::P_RTS] = q.port[k].rts;
							// [RULE_17] fixed framing
							r[pmc_pkg::P_DBITS +: 4] = pmc_pkg::DATA_BITS;
							r[pmc_pkg::P_PARITY] = 1'b0;
						end
					end
				end
			endcase
		end
		d.rdata = r;

		if (i_srst)
		begin
			d = '0;
			d.rate = pmc_pkg::RST_RATE;
			d.uid = pmc_pkg::RST_UID;
			d.vset = pmc_pkg::SET_POS;
			d.iset = pmc_pkg::SET_NONE;
			d.tcb = pmc_pkg::TCB_IGNORE;
			d.trea_en = pmc_pkg::RST_TREA;
			d.mask = pmc_pkg::RST_MASK;
			d.walk = WK_IDLE;
			for (int k = 0; k < NPORT; k++)
				d.port[k].baud = pmc_pkg::RST_BAUD;
		end
	end

	always_ff @(posedge i_clk)
	begin
		q <= d;
	end

	// [RULE_05] offset chosen per slot group
	assign ang.valid = (q.walk == WK_RUN) && slot_on(q.slot, q.vset, q.iset);
	assign ang.angle = i_meas_angle;
	assign ang.offset = (q.slot < pmc_pkg::SLOT_I1) ? q.voff : q.ioff;

	pmc_angle_corr u_corr (
		.i_clk  (i_clk),
		.i_srst (i_srst),
		.ang    (ang)
	);

	always_comb
	begin
		for (int k = 0; k < NPORT; k++)
		begin
			o_port_stream[k] = q.port[k].stream;
			o_port_silent[k] = q.port[k].stream && !q.en;
			o_port_baud[k] = q.port[k].baud;
			o_port_stop2[k] = q.port[k].stop2;
			o_port_rtscts[k] = q.port[k].rts;
		end
	end

	assign o_rdata = q.rdata;
	assign o_time_source_ok = q.time_source_ok;
	assign o_sample_strobe = q.samp;
	assign o_sample_sec = q.st_sec;
	assign o_sample_frac = q.st_frac;
	assign o_slot_id = q.slot;
	assign o_msg_start = q.msg;
	assign o_slot_valid = ang.out_valid;
	assign o_slot_tag = q.tag;
	assign o_slot_angle = ang.out_angle;
	assign o_pkt_analogs = q.en ? q.nana : 3'h0;
	assign o_pkt_digital = q.en && q.ndsw;
	assign o_trigger_reason_bits = q.trea;
	assign o_phasor_trigger = q.ptrig;
	assign o_cmd_accept = q.acc;
	assign o_cmd_reject = q.rej;

endmodule

// ==== verification/pmc_chk.sv ====
// Concurrent checks on the phasor configuration block ports
`timescale 1ns/1ps
module pmc_chk #(
	parameter int NPORT = 3,
	parameter int PW    = 2
) (
	input wire logic                    i_clk,
	input wire logic                    i_srst,
	input wire logic [3:0]              i_trig_src,
	input wire logic [3:0]              o_trigger_reason_bits,
	input wire logic                    o_phasor_trigger,
	input wire logic                    i_cmd_valid,
	input wire logic [PW-1:0]           i_cmd_port,
	input wire pmc_pkg::pmc_cmd_t       i_cmd_kind,
	input wire logic                    o_cmd_accept,
	input wire logic                    o_cmd_reject,
	input wire logic                    o_time_source_ok,
	input wire logic [NPORT-1:0]        o_port_stream,
	input wire logic [NPORT-1:0]        o_port_silent,
	input wire logic [NPORT-1:0][2:0]   o_port_baud,
	input wire logic                    o_msg_start,
	input wire logic [3:0]              o_slot_id,
	input wire logic                    o_slot_valid,
	input wire logic signed [15:0]      o_slot_angle,
	input wire logic                    o_sample_strobe,
	input wire logic [31:0]             o_sample_sec,
	input wire logic [2:0]              o_pkt_analogs
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	a_cmd_one_answer: assert property (
		i_cmd_valid |=> (o_cmd_accept ^ o_cmd_reject)) else $error("command answer count wrong");
	a_meter_refused: assert property (
		i_cmd_valid && i_cmd_kind == pmc_pkg::CMD_METER && !o_time_source_ok |=> o_cmd_reject)
		else $error("meter command taken without time source");
	a_stream_refused: assert property (
		i_cmd_valid && i_cmd_port != 0 && i_cmd_port <= NPORT && o_port_stream[i_cmd_port - 1'b1]
		|=> o_cmd_reject) else $error("streaming port took a command");
	a_silent_stream: assert property (
		(o_port_silent & ~o_port_stream) == 0) else $error("silent port not streaming");
	a_port1_no_stream: assert property (
		!o_port_stream[0]) else $error("first serial port streams");
	a_baud_legal: assert property (
		o_port_baud[0] <= 3'h6 && o_port_baud[1] <= 3'h6 && o_port_baud[2] <= 3'h6)
		else $error("illegal port speed");
	a_reason_cause: assert property (
		(o_trigger_reason_bits & ~$past(i_trig_src)) == 4'h0) else $error("reason bit without source");
	a_trig_cause: assert property (
		o_phasor_trigger |-> o_trigger_reason_bits != 4'h0) else $error("trigger without reason");
	a_slot_walk: assert property (
		o_msg_start |-> o_slot_id == 4'h0 ##5 o_slot_id == 4'h5 ##4 o_slot_id == 4'h9)
		else $error("slot walk out of order");
	a_angle_wrap: assert property (
		o_slot_valid |-> o_slot_angle > -16'sh4650 && o_slot_angle <= 16'sh4650)
		else $error("corrected angle out of range");
	a_stamp_hold: assert property (
		!o_sample_strobe |-> $stable(o_sample_sec)) else $error("stamp moved between samples");
	a_count_limit: assert property (
		o_pkt_analogs <= 3'h4) else $error("analog count above four");
endmodule

bind pmc_phasor_cfg pmc_chk #(.NPORT(NPORT), .PW(PW)) u_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_trig_src(i_trig_src),
	.o_trigger_reason_bits(o_trigger_reason_bits), .o_phasor_trigger(o_phasor_trigger),
	.i_cmd_valid(i_cmd_valid), .i_cmd_port(i_cmd_port), .i_cmd_kind(i_cmd_kind),
	.o_cmd_accept(o_cmd_accept), .o_cmd_reject(o_cmd_reject),
	.o_time_source_ok(o_time_source_ok), .o_port_stream(o_port_stream),
	.o_port_silent(o_port_silent), .o_port_baud(o_port_baud), .o_msg_start(o_msg_start),
	.o_slot_id(o_slot_id), .o_slot_valid(o_slot_valid), .o_slot_angle(o_slot_angle),
	.o_sample_strobe(o_sample_strobe), .o_sample_sec(o_sample_sec),
	.o_pkt_analogs(o_pkt_analogs));

// ==== verification/pmc_pdc_model.sv ====
// Far-side model: second-mark source and measured angle per slot
`timescale 1ns/1ps
module pmc_pdc_model #(
	parameter int SEC_CYC = 5000
) (
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	input  wire logic [3:0]         i_slot_id,
	output logic                    o_pps,
	output logic signed [15:0]      o_angle
);
	int cnt;

	always_ff @(posedge i_clk)
	begin
		cnt <= (i_srst || cnt == SEC_CYC - 1) ? 0 : cnt + 1;
		o_pps <= !i_srst && cnt < 10;
	end

	// slot angle 3000 steps from -9000
	assign o_angle = $signed({12'h000, i_slot_id}) * 16'sh0BB8 - 16'sh2328;
endmodule

// ==== verification/test_phasor_measurement_config.sv ====
// Self-checking bench for the phasor configuration block
`timescale 1ns/1ps
module test_phasor_measurement_config;
	logic clk = 0, srst = 1, wr = 0, rd = 0, pps, cv = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0, rdata, ssec, sfrac;
	logic [1:0] src = 2'h0, cport = 2'h1;
	pmc_pkg::pmc_cmd_t ckind = pmc_pkg::CMD_TEXT;
	logic [3:0] qual = 4'h0, tsrc = 4'h0, sid, stag, reas;
	logic signed [15:0] ang, sang;
	logic time_source_ok, sstb, msg, sv, dig, trig, acc, rej;
	logic [2:0] nana, pst, psil, pst2, prts;
	logic [2:0][2:0] pbaud;
	int n_mismatch = 0, checks_done = 0;

	pmc_phasor_cfg #(.SEC_CYC(5000), .SAMPLE_CYC(200)) dut (
		.i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
		.i_cfg_src(src), .o_rdata(rdata), .i_irig_pps(pps), .i_irig_qual(qual),
		.o_time_source_ok(time_source_ok), .o_sample_strobe(sstb), .o_sample_sec(ssec),
		.o_sample_frac(sfrac), .i_meas_angle(ang), .o_slot_id(sid), .o_msg_start(msg),
		.o_slot_valid(sv), .o_slot_tag(stag), .o_slot_angle(sang), .o_pkt_analogs(nana),
		.o_pkt_digital(dig), .i_trig_src(tsrc), .o_trigger_reason_bits(reas),
		.o_phasor_trigger(trig), .i_cmd_valid(cv), .i_cmd_port(cport), .i_cmd_kind(ckind),
		.o_cmd_accept(acc), .o_cmd_reject(rej), .o_port_stream(pst), .o_port_silent(psil),
		.o_port_baud(pbaud), .o_port_stop2(pst2), .o_port_rtscts(prts));
	pmc_pdc_model #(.SEC_CYC(5000)) pdc (.i_clk(clk), .i_srst(srst), .i_slot_id(sid),
		.o_pps(pps), .o_angle(ang));

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask

	task wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, e);
	endtask

	task wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		wrr(a, d);
		rdc(a, e);
	endtask

	task cmd(input logic [1:0] p, input pmc_pkg::pmc_cmd_t k, input logic e);
		@(posedge clk);
		cv <= 1;
		cport <= p;
		ckind <= k;
		@(posedge clk);
		cv <= 0;
		#1 chk({acc, rej}, {e, !e});
	endtask

	task cycles(input int n, output int ns, output int nm);
		ns = 0;
		nm = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1 ns += sstb;
			nm += msg;
		end
	endtask

	function automatic logic signed [15:0] wrp(input int s);
		if (s > 18000)
			s -= 36000;
		else if (s <= -18000)
			s += 36000;
		return 16'(s);
	endfunction

	task t_disabled;
		rdc(pmc_pkg::A_CTRL, 32'h0);
		rdc(pmc_pkg::A_UID, 32'h0);
		rdc(pmc_pkg::A_PORT0, 32'h808);
		rdc(8'hFC, 32'h0);
		wrc(pmc_pkg::A_PORT0, 32'h9, 32'h808);
		wrc(pmc_pkg::A_PORT0 + 8'h4, 32'h1F3D, 32'h83D);
		chk({pst, psil, pbaud[1], pst2, prts}, 15'h2592);
		cmd(2'h2, pmc_pkg::CMD_TEXT, 0);
		cmd(2'h2, pmc_pkg::CMD_FILE, 0);
		cmd(2'h1, pmc_pkg::CMD_TEXT, 1);
		cmd(2'h1, pmc_pkg::CMD_METER, 0);
		cmd(2'h0, pmc_pkg::CMD_TEXT, 0);
		src <= 2'h2;
		wrc(pmc_pkg::A_PORT0 + 8'h4, 32'h3C, 32'h83D);
		src <= 2'h0;
		wrc(pmc_pkg::A_PORT0 + 8'h4, 32'h3C, 32'h83C);
	endtask

	task t_settings;
		wrc(pmc_pkg::A_CTRL, 32'hA321, 32'hA321);
		chk({nana, dig}, 4'h9);
		rdc(pmc_pkg::A_UID, 32'h1);
		rdc(pmc_pkg::A_VOFF, 32'h0);
		wrc(pmc_pkg::A_IOFF, 32'h64, 32'h0);
		wrc(pmc_pkg::A_UID, 32'h0, 32'h1);
		wrc(pmc_pkg::A_UID, 32'hFFFF, 32'h1);
		wrc(pmc_pkg::A_UID, 32'hFFFE, 32'hFFFE);
		wrc(pmc_pkg::A_CTRL, 32'h1021, 32'h1021);
		wrc(pmc_pkg::A_CTRL, 32'h2021, 32'h2021);
		wrc(pmc_pkg::A_CTRL, 32'h5021, 32'h5021);
		wrc(pmc_pkg::A_CTRL, 32'h3021, 32'h5021);
		wrc(pmc_pkg::A_CTRL, 32'hA161, 32'hA021);
		wrc(pmc_pkg::A_CTRL, 32'hA02D, 32'hA021);
		wrc(pmc_pkg::A_CTRL, 32'hA031, 32'hA021);
		wrc(pmc_pkg::A_VOFF, 32'h4651, 32'h0);
		wrc(pmc_pkg::A_VOFF, 32'hFFFFB9B0, 32'h0);
		wrc(pmc_pkg::A_VOFF, 32'hFFFFB9B1, 32'hFFFFB9B1);
		wrc(pmc_pkg::A_VOFF, 32'h4650, 32'h4650);
		wrc(pmc_pkg::A_CTRL, 32'hA005, 32'hA005);
		wrc(pmc_pkg::A_IOFF, 32'hFFFFB9B1, 32'hFFFFB9B1);
	endtask

	task t_time;
		int ns, nm, k;
		cycles(1000, ns, nm);
		chk({time_source_ok, 31'(ns >= 4 && ns <= 6)}, 32'h1);
		chk(sfrac % 200, 199);
		k = 0;
		while (time_source_ok !== 1'b1 && k < 16000)
		begin
			@(posedge clk);
			#1 k++;
		end
		chk(time_source_ok, 1);
		cmd(2'h1, pmc_pkg::CMD_METER, 1);
		qual <= 4'hF;
		cycles(8, ns, nm);
		chk(time_source_ok, 1);
		wrr(pmc_pkg::A_CTRL, 32'hA007);
		cycles(4, ns, nm);
		chk(time_source_ok, 0);
		cmd(2'h1, pmc_pkg::CMD_METER, 0);
		qual <= 4'h0;
		wrr(pmc_pkg::A_CTRL, 32'hA005);
		cycles(2500, ns, nm);
		chk({time_source_ok, 31'(nm >= 4 && nm <= 6)}, 32'h80000001);
	endtask

	task t_packet;
		int n, k;
		k = 0;
		while (msg !== 1'b1 && k < 1000)
		begin
			@(posedge clk);
			#1 k++;
		end
		n = 0;
		repeat (12)
		begin
			@(posedge clk);
			#1
			if (sv === 1'b1)
			begin
				chk(stag, n);
				chk(32'(sang), 32'(wrp(n * 3000 - 9000 + (n < 5 ? 18000 : -17999))));
				n++;
			end
		end
		chk(n, 6);
	endtask

	task t_trig_off;
		int ns, nm;
		@(posedge clk);
		tsrc <= 4'h4;
		repeat (2) @(posedge clk);
		#1 chk({reas, trig}, 5'h9);
		tsrc <= 4'h0;
		repeat (2) @(posedge clk);
		#1 chk(trig, 0);
		wrr(pmc_pkg::A_CTRL, 32'h0);
		cycles(1500, ns, nm);
		chk(ns + nm, 0);
		rdc(pmc_pkg::A_VOFF, 32'h0);
		cmd(2'h1, pmc_pkg::CMD_METER, 0);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 0;
		t_disabled;
		t_settings;
		t_time;
		t_packet;
		t_trig_off;
		stop_test;
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		stop_test;
	end
endmodule
